// file: src/trgfc_pkg.sv
package trgfc_pkg;

	// Clock rate of the block.
	localparam int CLK_HZ = 25_000_000;

	// Times in their own units, with the derived cycle counts.
	localparam int PULSE_MIN_MS = 14;
	localparam int LAT_MIN_MS   = 1;
	localparam int LAT_MAX_MS   = 15;
	localparam int FILT_MS      = LAT_MIN_MS;
	localparam int LONG_MS      = 1000;
	// Scale the rate first: a product of ms and Hz overflows an int.
	localparam int FILT_CYC_DEF = FILT_MS * (CLK_HZ / 1000);
	localparam int LONG_CYC_DEF = LONG_MS * (CLK_HZ / 1000);

	// Counter widths sized for the default counts.
	localparam int FILT_W = 16;
	localparam int LONG_W = 25;

	// Data path widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int MODE_W = 3;

	// Register offsets.
	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_RANGE = 8'h04;
	localparam logic [7:0] REG_STAT  = 8'h08;

	// Field positions.
	localparam int CTRL_MODE_LSB   = 0;
	localparam int CTRL_RECEN_BIT  = 4;
	localparam int RANGE_FIRST_LSB = 0;
	localparam int RANGE_LAST_LSB  = 8;
	localparam int STAT_ADDR_LSB   = 0;
	localparam int STAT_LVL_BIT    = 8;
	localparam int STAT_LOCK_BIT   = 9;
	localparam int STAT_TRACK_BIT  = 10;
	localparam int STAT_ST_LSB     = 11;

	// Reset values.
	localparam logic [ADDR_W-1:0] ADDR_RST  = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
	localparam logic [LONG_W-1:0] LONG_ZERO = 25'h0000000;
	localparam logic [FILT_W-1:0] FILT_ZERO = 16'h0000;

	// Trigger function codes; unlisted codes act as off.
	typedef enum logic [MODE_W-1:0] {
		MODE_OFF             = 3'h0,
		MODE_STEP_RECALL     = 3'h1,
		MODE_RUN_CONTROL     = 3'h2,
		MODE_PANEL_LOCKOUT   = 3'h3,
		MODE_EXTREME_VALUE   = 3'h4
	} trgfc_mode_t;

	// Step recall sequencing states.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_STEP,
		ST_LONG
	} trgfc_step_t;

endpackage

// file: src/trgfc_filter.sv
`timescale 1ns/1ps
module trgfc_filter
	import trgfc_pkg::*;
#(
	parameter int FILT_CYC = FILT_CYC_DEF
)(
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic raw_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);

	logic              s1_r;
	logic              s2_r;
	logic              s3_r;
	logic              lvl_r;
	logic              rise_r;
	logic              fall_r;
	logic [FILT_W-1:0] cnt_r;
	logic [FILT_W-1:0] cnt_nxt;
	wire               agree;
	wire               differ;
	wire               done;

	// A new level counts only while the last two stages agree.
	assign agree   = (s2_r == s3_r);
	assign differ  = agree && (s3_r != lvl_r);
	// The hold time keeps short glitches out yet stays far below
	// the shortest legal pulse, so latency lands in its window.
	assign done    = differ && (cnt_r == FILT_W'(FILT_CYC - 1));
	assign cnt_nxt = (differ && !done) ? cnt_r + 1'b1 : FILT_ZERO;

	// Synchroniser chain; the first stage feeds only the second.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end
		else
		begin
			s1_r <= raw_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Filtered level and its edge pulses.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			cnt_r  <= FILT_ZERO;
			lvl_r  <= 1'b0;
			rise_r <= 1'b0;
			fall_r <= 1'b0;
		end
		else
		begin
			cnt_r  <= cnt_nxt;
			lvl_r  <= done ? s3_r : lvl_r;
			rise_r <= done && s3_r;
			fall_r <= done && !s3_r;
		end
	end

	assign level_o = lvl_r;
	assign rise_o  = rise_r;
	assign fall_o  = fall_r;

endmodule

// file: src/trgfc_top.sv
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module trgfc_top
	import trgfc_pkg::*;
#(
	parameter int FILT_CYC = FILT_CYC_DEF,
	parameter int LONG_CYC = LONG_CYC_DEF
)(
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	input  wire logic              trig_i,
	input  wire logic [7:0]        reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [DATA_W-1:0] reg_rdata_o,
	output logic      [ADDR_W-1:0] recall_addr_o,
	output logic                   recall_apply_o,
	output logic                   run_start_o,
	output logic                   run_stop_o,
	output logic      [ADDR_W-1:0] run_addr_o,
	output logic                   panel_lockout_o,
	output logic                   extreme_track_o,
	output logic                   extreme_reload_o
);

	// Filtered trigger.
	logic              lvl;
	logic              rise;
	logic              fall;
	// Software settings.
	trgfc_mode_t       mode_r;
	logic              rec_en_r;
	logic [ADDR_W-1:0] first_r;
	logic [ADDR_W-1:0] last_r;
	// Pulse width measurement.
	logic [LONG_W-1:0] hi_cnt_r;
	logic [LONG_W-1:0] hi_cnt_nxt;
	// Step recall sequencer.
	trgfc_step_t       st_r;
	trgfc_step_t       st_nxt;
	logic [ADDR_W-1:0] addr_r;
	logic [ADDR_W-1:0] addr_nxt;
	logic              apply_r;
	logic              apply_nxt;
	// Run control, lockout and recorder outputs.
	logic              start_r;
	logic              stop_r;
	logic [ADDR_W-1:0] run_addr_r;
	logic [ADDR_W-1:0] run_addr_nxt;
	logic              lock_r;
	logic              track_r;
	logic              reload_r;
	// Register read path.
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rd_val;
	// Decoded mode and trigger qualifiers.
	wire               is_step;
	wire               is_run;
	wire               is_lock;
	wire               is_ext;
	wire               long_evt;
	wire               hi_sat;
	wire               at_last;
	wire               wr_ctrl;
	wire               wr_range;
	wire               start_nxt;
	wire               stop_nxt;
	wire               lock_nxt;
	wire               track_nxt;
	wire               reload_nxt;

	trgfc_filter #(
		.FILT_CYC (FILT_CYC)
	) u_filter (
		.clk_i   (clk_i),
		.srst_i  (srst_i),
		.raw_i   (trig_i),
		.level_o (lvl),
		.rise_o  (rise),
		.fall_o  (fall)
	);

	// Unlisted codes act as off, so a bad write can do no harm.
	assign is_step = (mode_r == MODE_STEP_RECALL);
	assign is_run  = (mode_r == MODE_RUN_CONTROL);
	assign is_lock = (mode_r == MODE_PANEL_LOCKOUT);
	assign is_ext  = (mode_r == MODE_EXTREME_VALUE);

	// The counter saturates, so one long event fires per pulse.
	assign hi_sat     = (hi_cnt_r == LONG_W'(LONG_CYC));
	assign long_evt   = lvl && (hi_cnt_r == LONG_W'(LONG_CYC - 1));
	assign hi_cnt_nxt = !lvl ? LONG_ZERO :
		(hi_sat ? hi_cnt_r : hi_cnt_r + 1'b1);

	// Wrap also when a shrunk range leaves the pointer above the end.
	assign at_last = (addr_r >= last_r);

	// Step recall next state; a long hold wins over any edge.
	always_comb
	begin
		st_nxt    = ST_IDLE;
		addr_nxt  = addr_r;
		apply_nxt = 1'b0;
		if (is_step && long_evt && (st_r != ST_LONG))
		begin
			addr_nxt = first_r;
			st_nxt   = ST_LONG;
		end
		else if (is_step)
		begin
			case (st_r)
				ST_IDLE:
				begin
					st_nxt    = fall ? ST_STEP : ST_IDLE;
					addr_nxt  = fall ? first_r : addr_r;
					apply_nxt = fall;
				end
				ST_STEP:
				begin
					st_nxt    = ST_STEP;
					apply_nxt = fall;
					if (fall)
						addr_nxt = at_last ? first_r :
							ADDR_W'(addr_r + 1'b1);
				end
				// The release of a long pulse is no step.
				ST_LONG:
					st_nxt = fall ? ST_IDLE : ST_LONG;
				default:
					st_nxt = ST_IDLE;
			endcase
		end
	end

	// Run control launches at first and ends by jumping to last.
	assign start_nxt    = is_run && rise;
	assign stop_nxt     = is_run && fall;
	assign run_addr_nxt = start_nxt ? first_r :
		(stop_nxt ? last_r : run_addr_r);

	// Lockout covers the local key; the mains switch is not logic.
	assign lock_nxt = is_lock && lvl;

	// Recorder gating. With the recorder disabled nothing is tracked.
	assign track_nxt  = rec_en_r && !(is_ext && lvl);
	assign reload_nxt = rec_en_r && is_ext && fall;

	// Software writes.
	assign wr_ctrl  = reg_wr_i && (reg_addr_i == REG_CTRL);
	assign wr_range = reg_wr_i && (reg_addr_i == REG_RANGE);

	// Register readback; unmapped addresses read zero.
	always_comb
	begin
		rd_val = DATA_ZERO;
		if (reg_addr_i == REG_CTRL)
		begin
			rd_val[CTRL_MODE_LSB +: MODE_W] = mode_r;
			rd_val[CTRL_RECEN_BIT]          = rec_en_r;
		end
		else if (reg_addr_i == REG_RANGE)
		begin
			rd_val[RANGE_FIRST_LSB +: ADDR_W] = first_r;
			rd_val[RANGE_LAST_LSB +: ADDR_W]  = last_r;
		end
		else if (reg_addr_i == REG_STAT)
		begin
			rd_val[STAT_ADDR_LSB +: ADDR_W] = addr_r;
			rd_val[STAT_LVL_BIT]            = lvl;
			rd_val[STAT_LOCK_BIT]           = lock_r;
			rd_val[STAT_TRACK_BIT]          = track_r;
			rd_val[STAT_ST_LSB +: 2]        = st_r;
		end
	end

	// Settings registers.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			mode_r   <= MODE_OFF;
			rec_en_r <= 1'b0;
			first_r  <= ADDR_RST;
			last_r   <= ADDR_RST;
		end
		else
		begin
			if (wr_ctrl)
			begin
				mode_r   <= trgfc_mode_t'(
					reg_wdata_i[CTRL_MODE_LSB +: MODE_W]);
				rec_en_r <= reg_wdata_i[CTRL_RECEN_BIT];
			end
			if (wr_range)
			begin
				first_r <= reg_wdata_i[RANGE_FIRST_LSB +: ADDR_W];
				last_r  <= reg_wdata_i[RANGE_LAST_LSB +: ADDR_W];
			end
		end
	end

	// Read data stand for exactly one cycle after the strobe.
	always_ff @(posedge clk_i)
	begin
		rdata_r <= (reg_rd_i && !srst_i) ? rd_val : DATA_ZERO;
	end

	// Sequencer, width counter and outputs, one cycle after the edge.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			st_r       <= ST_IDLE;
			addr_r     <= ADDR_RST;
			apply_r    <= 1'b0;
			hi_cnt_r   <= LONG_ZERO;
			start_r    <= 1'b0;
			stop_r     <= 1'b0;
			run_addr_r <= ADDR_RST;
			lock_r     <= 1'b0;
			track_r    <= 1'b0;
			reload_r   <= 1'b0;
		end
		else
		begin
			st_r       <= st_nxt;
			addr_r     <= addr_nxt;
			apply_r    <= apply_nxt;
			hi_cnt_r   <= hi_cnt_nxt;
			start_r    <= start_nxt;
			stop_r     <= stop_nxt;
			run_addr_r <= run_addr_nxt;
			lock_r     <= lock_nxt;
			track_r    <= track_nxt;
			reload_r   <= reload_nxt;
		end
	end

	assign reg_rdata_o      = rdata_r;
	assign recall_addr_o    = addr_r;
	assign recall_apply_o   = apply_r;
	assign run_start_o      = start_r;
	assign run_stop_o       = stop_r;
	assign run_addr_o       = run_addr_r;
	assign panel_lockout_o  = lock_r;
	assign extreme_track_o  = track_r;
	assign extreme_reload_o = reload_r;

	// One clock and one reset serve every check below.
	default clocking cb_chk @(posedge clk_i);
	endclocking
	default disable iff (srst_i);
	// Named steps of the step recall sequence.
	sequence s_idle_fall;
		is_step && (st_r == ST_IDLE) && fall;
	endsequence
	sequence s_step_fall_mid;
		is_step && (st_r == ST_STEP) && fall && !at_last;
	endsequence
	sequence s_step_fall_end;
		is_step && (st_r == ST_STEP) && fall && at_last;
	endsequence
	sequence s_apply_first;
		recall_apply_o && (recall_addr_o == $past(first_r));
	endsequence

	AST_OFF_IGNORE: assert property ((mode_r == MODE_OFF) |=>
		!(recall_apply_o || run_start_o || run_stop_o ||
			panel_lockout_o || extreme_reload_o))
		else $error("Trigger acted while the function was off.");
	AST_STEP_FIRST: assert property (s_idle_fall |=> s_apply_first)
		else $error("Recall did not start at the first address.");
	AST_STEP_INC: assert property (s_step_fall_mid |=>
		recall_apply_o && (recall_addr_o == $past(addr_r) + 1'b1)
			##1 !recall_apply_o)
		else $error("Step did not add one to the recall address.");
	AST_STEP_WRAP: assert property (s_step_fall_end |=>
		s_apply_first)
		else $error("Step after the last address did not wrap.");
	AST_STEP_LONG: assert property ((is_step && long_evt) |=>
		(recall_addr_o == $past(first_r)) &&
			!recall_apply_o && (st_r == ST_LONG))
		else $error("Long pulse did not return to the first address.");
	AST_STEP_NOSTEP: assert property ((st_r == ST_LONG) && fall |=>
		!recall_apply_o && $stable(recall_addr_o))
		else $error("Release of a long pulse stepped the run.");
	AST_RUN_START: assert property (is_run && rise |=>
		run_start_o && !run_stop_o && (run_addr_o == $past(first_r)))
		else $error("Run did not start at the first address.");
	AST_RUN_STOP: assert property (is_run && fall |=>
		run_stop_o && !run_start_o && (run_addr_o == $past(last_r)))
		else $error("Run did not end at the last address.");
	AST_LOCK_LOW: assert property (is_lock && !lvl |=>
		!panel_lockout_o)
		else $error("Panel locked while trigger low.");
	AST_LOCK_HIGH: assert property (is_lock && lvl |=>
		panel_lockout_o)
		else $error("Panel not locked while trigger high.");
	AST_EXT_GATE: assert property (!rec_en_r |=>
		!extreme_track_o && !extreme_reload_o)
		else $error("Recorder active while disabled.");
	AST_EXT_TRACK: assert property (rec_en_r && is_ext && !lvl |=>
		extreme_track_o)
		else $error("Recorder not tracking while trigger low.");
	AST_EXT_HALT: assert property (rec_en_r && is_ext && rise |=>
		!extreme_track_o && !extreme_reload_o)
		else $error("Rising edge did not halt the recorder.");
	AST_EXT_HOLD: assert property (rec_en_r && is_ext && lvl &&
		!fall |=> !extreme_track_o)
		else $error("Recorder updated while trigger high.");
	AST_EXT_RELOAD: assert property (rec_en_r && is_ext && fall |=>
		extreme_reload_o && extreme_track_o ##1 !extreme_reload_o)
		else $error("Falling edge did not reload the recorder.");

endmodule

// file: verif/trgfc_trig_src.sv
`timescale 1ns/1ps
// Outside control source: one high pulse of a chosen width per request.
module trgfc_trig_src (
	input  wire logic        clk_i,
	input  wire logic        go_i,
	input  wire logic [15:0] width_i,
	output logic             trig_o,
	output logic             busy_o
);
	logic [15:0] hold_r = 16'h0000;

	// Widths stay above the filter span, save one deliberate glitch.
	always @(posedge clk_i)
	begin
		if (go_i)
			hold_r <= width_i;
		else if (hold_r != 16'h0000)
			hold_r <= hold_r - 16'h0001;
	end

	// The switch holds the line low between pulses.
	assign trig_o = (hold_r != 16'h0000);
	assign busy_o = trig_o;
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	import trgfc_pkg::*;
	localparam int FC = 4;
	localparam int LC = 64;
	logic              clk_i = 1'b0;
	logic              srst_i;
	logic [7:0]        reg_addr_i;
	logic [DATA_W-1:0] reg_wdata_i;
	logic              reg_wr_i;
	logic              reg_rd_i;
	logic [DATA_W-1:0] reg_rdata_o;
	logic [ADDR_W-1:0] recall_addr_o;
	logic [ADDR_W-1:0] run_addr_o;
	logic              recall_apply_o;
	logic              run_start_o;
	logic              run_stop_o;
	logic              panel_lockout_o;
	logic              extreme_track_o;
	logic              extreme_reload_o;
	logic              trig;
	logic              go;
	logic              busy;
	logic [15:0]       width;
	logic [15:0]       d;
	int                fails = 0;
	int                checks_done = 0;
	int                n_ap = 0;
	int                n_st = 0;
	int                n_sp = 0;
	int                n_rl = 0;
	int                e_ap = 0;
	int                first;
	int                last;
	int                addr = 0;
	int                stepping = 0;
	int                snap;
	integer            seed = 32'he5c7;
	int                modes[5] = '{0, 4, 5, 6, 7};

	trgfc_trig_src trgfc_trig_src_inst (
		.clk_i   (clk_i),
		.go_i    (go),
		.width_i (width),
		.trig_o  (trig),
		.busy_o  (busy)
	);

	trgfc_top #(.FILT_CYC(FC), .LONG_CYC(LC)) trgfc_top_inst (
		.clk_i            (clk_i),
		.srst_i           (srst_i),
		.trig_i           (trig),
		.reg_addr_i       (reg_addr_i),
		.reg_wdata_i      (reg_wdata_i),
		.reg_wr_i         (reg_wr_i),
		.reg_rd_i         (reg_rd_i),
		.reg_rdata_o      (reg_rdata_o),
		.recall_addr_o    (recall_addr_o),
		.recall_apply_o   (recall_apply_o),
		.run_start_o      (run_start_o),
		.run_stop_o       (run_stop_o),
		.run_addr_o       (run_addr_o),
		.panel_lockout_o  (panel_lockout_o),
		.extreme_track_o  (extreme_track_o),
		.extreme_reload_o (extreme_reload_o)
	);

	// Free running clock at 25 MHz.
	always #20 clk_i = ~clk_i;

	// Pulses last one cycle, so they are counted at every edge.
	always @(posedge clk_i)
	begin
		if (recall_apply_o === 1'b1) n_ap++;
		if (run_start_o === 1'b1) n_st++;
		if (run_stop_o === 1'b1) n_sp++;
		if (extreme_reload_o === 1'b1) n_rl++;
	end

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= v;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask

	task fire(input int w);
		@(posedge clk_i);
		go    <= 1'b1;
		width <= w[15:0];
		@(posedge clk_i);
		go <= 1'b0;
	endtask

	// Waits out the pulse, then the filter and output latency.
	task settle;
		int i;
		i = 0;
		// Step off the edge so a pulse loaded at it is already seen.
		#1;
		while (busy === 1'b1 && i < 2000)
		begin
			@(posedge clk_i);
			i++;
		end
		if (i >= 2000) fails++;
		repeat (FC + 12) @(posedge clk_i);
		#1;
	endtask

	// One short pulse, checked against the stepping model.
	task stepp(input int w);
		fire(w);
		settle;
		if (stepping == 0) addr = first;
		else if (addr >= last) addr = first;
		else addr++;
		stepping = 1;
		e_ap++;
		chk("apply_count", n_ap[15:0], e_ap[15:0]);
		chk("recall_addr", {8'h00, recall_addr_o}, addr[15:0]);
	endtask

	initial
	begin
		repeat (60000) @(posedge clk_i);
		fails++;
		$display("watchdog expired");
		wrap_up;
	end

	initial
	begin
		srst_i = 1'b1;
		reg_addr_i = 8'h00;
		reg_wdata_i = 16'h0000;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		go = 1'b0;
		width = 16'h0000;
		repeat (4) @(posedge clk_i);
		srst_i <= 1'b0;
		rd(REG_CTRL, d);
		chk("ctrl_rst", d, 16'h0000);
		rd(REG_RANGE, d);
		chk("range_rst", d, 16'h0000);
		rd(REG_STAT, d);
		chk("stat_rst", d, 16'h0000);
		wr(8'h0C, 16'hFFFF);
		rd(8'h0C, d);
		chk("unmapped", d, 16'h0000);
		rd(REG_CTRL, d);
		chk("ctrl_kept", d, 16'h0000);
		wr(REG_RANGE, 16'h0402);
		rd(REG_RANGE, d);
		chk("range_rb", d, 16'h0402);
		$display("test registers done");
		first = 2;
		last = 4;
		wr(REG_CTRL, 16'h0001);
		repeat (5) stepp(8 + ($unsigned($random(seed)) % 33));
		fire(2);
		settle;
		chk("glitch", n_ap[15:0], e_ap[15:0]);
		fire(LC + 40);
		settle;
		stepping = 0;
		addr = first;
		chk("long_addr", {8'h00, recall_addr_o}, 16'h0002);
		chk("long_noapply", n_ap[15:0], e_ap[15:0]);
		stepp(12);
		rd(REG_STAT, d);
		chk("stat", d, 16'h0800 | addr[15:0]);
		wr(REG_RANGE, 16'h0707);
		wr(REG_CTRL, 16'h0000);
		wr(REG_CTRL, 16'h0001);
		first = 7;
		last = 7;
		stepping = 0;
		repeat (3) stepp(11);
		$display("test step recall done");
		wr(REG_RANGE, 16'h0905);
		wr(REG_CTRL, 16'h0002);
		fire(40);
		repeat (FC + 12) @(posedge clk_i);
		#1 chk("run_start", n_st[15:0], 16'h0001);
		chk("run_first", {8'h00, run_addr_o}, 16'h0005);
		settle;
		chk("run_stop", n_sp[15:0], 16'h0001);
		chk("run_last", {8'h00, run_addr_o}, 16'h0009);
		$display("test run control done");
		wr(REG_CTRL, 16'h0003);
		#1 chk("lock_low", {15'h0000, panel_lockout_o}, 16'h0000);
		fire(40);
		repeat (FC + 12) @(posedge clk_i);
		#1 chk("lock_high", {15'h0000, panel_lockout_o}, 16'h0001);
		settle;
		chk("lock_rel", {15'h0000, panel_lockout_o}, 16'h0000);
		$display("test panel lockout done");
		wr(REG_CTRL, 16'h0014);
		repeat (3) @(posedge clk_i);
		#1 chk("track_low", {15'h0000, extreme_track_o}, 16'h0001);
		fire(40);
		repeat (FC + 12) @(posedge clk_i);
		#1 chk("track_halt", {15'h0000, extreme_track_o}, 16'h0000);
		repeat (10) @(posedge clk_i);
		#1 chk("track_held", {15'h0000, extreme_track_o}, 16'h0000);
		chk("no_reload", n_rl[15:0], 16'h0000);
		settle;
		chk("reload", n_rl[15:0], 16'h0001);
		chk("track_again", {15'h0000, extreme_track_o}, 16'h0001);
		$display("test extreme value done");
		foreach (modes[k])
		begin
			wr(REG_CTRL, modes[k][15:0]);
			snap = n_ap + n_st + n_sp + n_rl;
			fire(20);
			settle;
			d = 16'(n_ap + n_st + n_sp + n_rl);
			chk("idle_pulses", d, snap[15:0]);
			chk("idle_lock", {15'h0000, panel_lockout_o}, 16'h0000);
			chk("idle_track", {15'h0000, extreme_track_o}, 16'h0000);
			rd(REG_CTRL, d);
			chk("mode_rb", d, modes[k][15:0]);
		end
		$display("test inactive modes done");
		wrap_up;
	end
endmodule
